// ### verilog/ttc_pkg.sv
/*
 * Constants for the tone transmit control block: register bit positions,
 * port address codes, reset values and burst timing.
 * Assumes a 125 MHz system clock.
 */
package ttc_pkg;
    // Second control register bit positions.
    localparam int CRB_BURST_N = 0;
    localparam int CRB_TEST = 1;
    localparam int CRB_SINGLE = 2;
    localparam int CRB_COLUMN = 3;
    // First control register bit positions.
    localparam int CRA_TONE_ON = 0;
    localparam int CRA_CALL_MODE = 1;
    localparam int CRA_IRQ_EN = 2;
    localparam int CRA_ROUTE = 3;
    // Status register bit positions.
    localparam int STAT_IRQ = 0;
    localparam int STAT_TX_EMPTY = 1;
    // Register-select pin codes.
    localparam logic ADDR_DATA = 1'h0;
    localparam logic ADDR_CTRL = 1'h1;
    // Reset values.
    localparam logic [3:0] CRA_RESET = 4'h0;
    localparam logic [3:0] CRB_RESET = 4'h0;
    // Burst and pause length in DTMF mode, milliseconds.
    localparam int BURST_MS = 51;
    localparam int CLK_KHZ = 125000;
    localparam int BURST_CYCLES = BURST_MS * CLK_KHZ;
endpackage

// ### verilog/ttc_tone_transmit_control.sv
/*
 * Control registers, status flags and transmit burst sequencing of a
 * tone transceiver, written by a host over a 4-bit parallel port.
 * Assumes the host strobes are synchronous to clk; the steering input
 * arrives from another domain and is resynchronised here.
 */
// Summary of operation
// RULE1: Burst bit zero selects timed burst mode.
// RULE2: Digit write starts burst, equal pause follows.
// RULE3: After pause, flag empty and interrupt.
// RULE4: Call-progress plus burst doubles burst and pause.
// RULE5: Burst bit one: tones while host enables.
// RULE6: Test bit drives pin with inverted steering.
// RULE7: Host selects DTMF mode before test mode.
// RULE8: Single bit clear gives row plus column.
// RULE9: Single bit set gives one group only.
// RULE10: Column bit zero row, one column.
// RULE11: Route bit sends next control write second.
// RULE12: Ready interrupt only when interrupt enabled.
// RULE13: Empty flag: set on pause end, cleared.
`timescale 1ns/1ps
module ttc_tone_transmit_control
    import ttc_pkg::*;
#(
    parameter int BurstCycles = BURST_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic writeStb,
    input wire logic readStb,
    input wire logic regSel,
    input wire logic [3:0] wrData,
    input wire logic steeringIn,
    output logic [3:0] rdData,
    output logic [3:0] toneCode,
    output logic rowToneOn,
    output logic colToneOn,
    output logic interruptToneOutN,
    output logic interruptToneOe,
    output logic [3:0] controlRegFirst,
    output logic [3:0] controlRegSecond
);
    typedef enum logic [1:0] {TTC_IDLE, TTC_BURST, TTC_PAUSE} ttc_state_t;

    // Sized for the doubled call-progress length so the counter cannot wrap.
    localparam int CntW = $clog2(2 * BurstCycles + 1);

    ttc_state_t state_reg, state_next;
    logic [CntW-1:0] cnt_reg, cnt_next;
    logic [3:0] cra_reg, cra_next;
    logic [3:0] crb_reg, crb_next;
    logic route_reg, route_next;
    logic [3:0] code_reg, code_next;
    logic empty_reg, empty_next;
    logic [2:0] steerSync_reg;
    logic [2:0] steerSync_next;
    logic steer_reg, steer_next;
    logic [3:0] rdData_next;
    logic rowOn_next, colOn_next;
    logic pinLow_next;
    logic burstMode, callMode, toneEnable, pauseDone;
    logic [CntW-1:0] burstLen;

    // One decode of a host access, shared by the registers, the sequencer and the flag.
    function automatic logic host_access(input logic stb, input logic sel, input logic code);
        return stb && (sel == code);
    endfunction

    assign burstMode = ~crb_reg[CRB_BURST_N]; // RULE1
    assign callMode = cra_reg[CRA_CALL_MODE];
    // Doubling in call-progress mode keeps the burst and pause equal.
    assign burstLen = callMode ? CntW'(2 * BurstCycles) : CntW'(BurstCycles); // RULE4
    assign pauseDone = (state_reg == TTC_PAUSE) && (cnt_reg == CntW'(1));

    // Control registers and the route toggle.
    always_comb begin
        cra_next = cra_reg;
        crb_next = crb_reg;
        route_next = route_reg;
        code_next = code_reg;
        if (host_access(writeStb, regSel, ADDR_CTRL)) begin
            // Only the next control write after a route bit is steered to the second register.
            if (route_reg) begin
                crb_next = wrData; // RULE11
                route_next = 1'b0; // RULE11
            end else begin
                cra_next = wrData;
                route_next = wrData[CRA_ROUTE]; // RULE11
            end
        end
        if (host_access(writeStb, regSel, ADDR_DATA)) begin
            code_next = wrData;
        end
    end

    // Burst sequencer and transmit-empty flag.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        empty_next = empty_reg;
        unique case (state_reg)
            TTC_IDLE: begin
                // Only an idle sequencer starts a burst; a digit written during a burst or pause changes the code but starts none.
                if (burstMode && host_access(writeStb, regSel, ADDR_DATA)) begin
                    state_next = TTC_BURST; // RULE2
                    cnt_next = burstLen;
                end
            end
            TTC_BURST: begin
                if (cnt_reg == CntW'(1)) begin
                    state_next = TTC_PAUSE; // RULE2
                    cnt_next = burstLen;
                end else begin
                    cnt_next = cnt_reg - CntW'(1);
                end
            end
            TTC_PAUSE: begin
                if (pauseDone) begin
                    state_next = TTC_IDLE;
                end else begin
                    cnt_next = cnt_reg - CntW'(1);
                end
            end
            default: begin
                state_next = TTC_IDLE;
                cnt_next = '0;
            end
        endcase
        // A pause end beats a status read in the same cycle, so no ready event is lost.
        if (!burstMode) begin
            state_next = TTC_IDLE; // RULE5
            empty_next = 1'b0; // RULE13
        end else if (pauseDone) begin
            empty_next = 1'b1; // RULE3 RULE13
        end else if (host_access(readStb, regSel, ADDR_CTRL)) begin
            empty_next = 1'b0; // RULE13
        end
    end

    // Tone outputs, pin and read data.
    always_comb begin
        steerSync_next = {steerSync_reg[1:0], steeringIn};
        steer_next = steer_reg;
        // The pin is only trusted once two later stages agree.
        if (steerSync_reg[1] == steerSync_reg[2]) begin
            steer_next = steerSync_reg[2];
        end
        // Tones follow the register copies by one cycle; a burst starts on the write edge itself.
        toneEnable = cra_reg[CRA_TONE_ON] && (burstMode ? (state_next == TTC_BURST) : 1'b1); // RULE2 RULE5
        rowOn_next = toneEnable && (!crb_reg[CRB_SINGLE] || !crb_reg[CRB_COLUMN]); // RULE8 RULE9 RULE10
        colOn_next = toneEnable && (!crb_reg[CRB_SINGLE] || crb_reg[CRB_COLUMN]); // RULE8 RULE9 RULE10
        // Test mode only takes effect while DTMF mode is selected.
        if (crb_reg[CRB_TEST] && !callMode) begin
            pinLow_next = steer_next; // RULE6 RULE7
        end else begin
            pinLow_next = cra_reg[CRA_IRQ_EN] && burstMode && empty_next; // RULE3 RULE12
        end
        // The interrupt bit mirrors the empty flag, the only interrupt source here.
        rdData_next = 4'h0;
        if (regSel == ADDR_CTRL) begin
            rdData_next[STAT_TX_EMPTY] = empty_reg;
            rdData_next[STAT_IRQ] = empty_reg;
        end
    end

    // Control registers, route toggle and digit code.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cra_reg <= CRA_RESET;
            crb_reg <= CRB_RESET;
            route_reg <= 1'b0;
            code_reg <= 4'h0;
        end else begin
            cra_reg <= cra_next;
            crb_reg <= crb_next;
            route_reg <= route_next;
            code_reg <= code_next;
        end
    end

    // Sequencer state, length counter and empty flag.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= TTC_IDLE;
            cnt_reg <= '0;
            empty_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            empty_reg <= empty_next;
        end
    end

    // Steering synchroniser and registered outputs.
    // Open-drain pin: the level stays low and only the enable moves.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            steerSync_reg <= 3'h0;
            steer_reg <= 1'b0;
            rdData <= 4'h0;
            toneCode <= 4'h0;
            rowToneOn <= 1'b0;
            colToneOn <= 1'b0;
            interruptToneOutN <= 1'b0;
            interruptToneOe <= 1'b0;
            controlRegFirst <= CRA_RESET;
            controlRegSecond <= CRB_RESET;
        end else begin
            steerSync_reg <= steerSync_next;
            steer_reg <= steer_next;
            rdData <= rdData_next;
            toneCode <= code_next;
            rowToneOn <= rowOn_next;
            colToneOn <= colOn_next;
            interruptToneOutN <= 1'b0;
            interruptToneOe <= pinLow_next;
            controlRegFirst <= cra_next;
            controlRegSecond <= crb_next;
        end
    end
endmodule

// ### testbench/ttc_chk.sv
/* Checker on the tone transmit control ports.
   Bound to every instance; one clock domain. */
`timescale 1ns/1ps
module ttc_chk #(
    parameter int BurstCycles = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic writeStb,
    input wire logic regSel,
    input wire logic [3:0] wrData,
    input wire logic rowToneOn,
    input wire logic colToneOn,
    input wire logic interruptToneOe,
    input wire logic [3:0] controlRegFirst,
    input wire logic [3:0] controlRegSecond
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic routeReg;
    logic [15:0] onCnt;
    always_ff @(posedge clk) begin
        routeReg <= rstn && ((writeStb && regSel) ? (!routeReg && wrData[3]) : routeReg);
        onCnt <= rowToneOn ? onCnt + 16'h1 : 16'h0;
    end
    property p_len; $fell(rowToneOn) && !controlRegSecond[0] |-> onCnt == BurstCycles * (controlRegFirst[1] ? 2 : 1); endproperty
    a_len: assert property (p_len) else $error("burst length");
    property p_pause; $fell(rowToneOn) && !controlRegSecond[0] |-> (!rowToneOn && !interruptToneOe) [*4]; endproperty
    a_pause: assert property (p_pause) else $error("pause");
    property p_ready; $fell(rowToneOn) && !controlRegSecond[0] && controlRegFirst[2:1] == 2'h2 |-> ##[4:6] interruptToneOe; endproperty
    a_ready: assert property (p_ready) else $error("ready pin");
    property p_second; writeStb && regSel && routeReg |=> controlRegSecond == $past(wrData); endproperty
    a_second: assert property (p_second) else $error("second write");
    property p_first; writeStb && regSel && !routeReg |=> controlRegFirst == $past(wrData); endproperty
    a_first: assert property (p_first) else $error("first write");
    property p_dual; controlRegFirst[0] && controlRegSecond[0] && !controlRegSecond[2] |=> rowToneOn && colToneOn; endproperty
    a_dual: assert property (p_dual) else $error("dual tones");
    property p_single; controlRegSecond[2] && controlRegFirst[0] && controlRegSecond[0]
        |=> rowToneOn != $past(controlRegSecond[3]) && colToneOn == $past(controlRegSecond[3]); endproperty
    a_single: assert property (p_single) else $error("single tone");
    property p_noirq; !controlRegFirst[2] && !controlRegSecond[1] |=> !interruptToneOe; endproperty
    a_noirq: assert property (p_noirq) else $error("masked pin");
endmodule
bind ttc_tone_transmit_control ttc_chk #(.BurstCycles(BurstCycles)) i_chk (.clk(clk), .rstn(rstn),
    .writeStb(writeStb), .regSel(regSel), .wrData(wrData), .rowToneOn(rowToneOn), .colToneOn(colToneOn),
    .interruptToneOe(interruptToneOe), .controlRegFirst(controlRegFirst), .controlRegSecond(controlRegSecond));

// ### testbench/ttc_host.sv
/* Host model for the register port.
   Requests change 1 ns after a rising edge and last one cycle. */
`timescale 1ns/1ps
module ttc_host (
    input wire logic clk,
    output logic writeStb = 1'h0,
    output logic readStb = 1'h0,
    output logic regSel = 1'h0,
    output logic [3:0] wrData = 4'h0
);
    // Released data lines flip so a stale value cannot pass.
    task automatic wr(input logic sel, input logic [3:0] d);
        @(posedge clk);
        #1;
        writeStb = 1'h1;
        regSel = sel;
        wrData = d;
        @(posedge clk);
        #1;
        writeStb = 1'h0;
        wrData = ~d;
    endtask
    task automatic rd();
        @(posedge clk);
        #1;
        readStb = 1'h1;
        regSel = 1'h1;
        @(posedge clk);
        #1;
        readStb = 1'h0;
    endtask
endmodule

// ### testbench/test_tone_transmit_control.sv
/* Testbench for the tone transmit control block.
   Burst shortened to 4 cycles; 125 MHz clock. */
`timescale 1ns/1ps
module test_tone_transmit_control;
    localparam int N = 4;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic steeringIn = 1'h0;
    logic writeStb, readStb, regSel, rowToneOn, colToneOn, pinOe, pinOut;
    logic rdPend = 1'h0;
    logic [3:0] wrData, rdData, toneCode, control_reg_first, control_reg_second, digit;
    logic [3:0] modes[3] = '{4'h1, 4'h5, 4'hd};
    logic [3:0] tones[3] = '{4'h3, 4'h2, 4'h1};
    logic [3:0] expQ[$];
    int numErrors = 0;
    int checkCount = 0;
    int n;
    initial forever #4 clk = ~clk;
    ttc_host i_host (.clk(clk), .writeStb(writeStb), .readStb(readStb), .regSel(regSel), .wrData(wrData));
    ttc_tone_transmit_control #(.BurstCycles(N)) i_dut (.clk(clk), .rstn(rstn), .writeStb(writeStb),
        .readStb(readStb), .regSel(regSel), .wrData(wrData), .steeringIn(steeringIn), .rdData(rdData),
        .toneCode(toneCode), .rowToneOn(rowToneOn), .colToneOn(colToneOn), .interruptToneOutN(pinOut),
        .interruptToneOe(pinOe), .controlRegFirst(control_reg_first), .controlRegSecond(control_reg_second));
    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        checkCount++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finalReport();
        $display("errors %0d checks %0d", numErrors, checkCount);
        if (numErrors == 0 && checkCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic status(input logic [3:0] exp);
        expQ.push_back(exp);
        i_host.rd();
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        if (rdPend) begin
            check("status", rdData, expQ.pop_front());
        end
        rdPend <= readStb;
    end
    initial begin
        void'($urandom(26100));
        idle(2);
        rstn = 1'h1;
        for (int cp = 0; cp < 2; cp++) begin
            i_host.wr(1'h1, (cp != 0) ? 4'hb : 4'hd);
            i_host.wr(1'h1, 4'h0);
            digit = 4'($urandom);
            i_host.wr(1'h0, digit);
            check("code", toneCode, digit);
            check("tones", {rowToneOn, colToneOn}, 4'h3);
            n = 0;
            while (rowToneOn === 1'h1 && n < 100) begin
                idle(1);
                n++;
            end
            if (n == 100) begin
                numErrors++;
                finalReport();
            end
            idle(N * (cp + 1) - 3);
            status(4'h0);
            idle(2);
            check("pin", pinOe, (cp != 0) ? 4'h0 : 4'h1);
            check("pin level", pinOut, 4'h0);
            status(4'h3);
            idle(2);
            check("pin", pinOe, 4'h0);
        end
        foreach (modes[i]) begin
            i_host.wr(1'h1, 4'h9);
            i_host.wr(1'h1, modes[i]);
            idle(N * 4);
            check("tones", {rowToneOn, colToneOn}, tones[i]);
        end
        status(4'h0);
        i_host.wr(1'h1, 4'h8);
        i_host.wr(1'h1, 4'h3);
        for (int s = 0; s < 2; s++) begin
            steeringIn = (s == 0);
            idle(6);
            check("steer", pinOe, {3'h0, steeringIn});
        end
        finalReport();
    end
endmodule
